// ### hw/wdg_top.sv
// Contract
// - Every write to the mode register stretches the access by one wait cycle.
// - Upper mode bits are 0,1,1; in the unstoppable option others are ignored.
// - Only one byte write to the mode register is taken; a second one resets.
// - An access fault while the source clock is stopped resets once it runs.
// - Single-bit accesses never alter the mode register; only byte writes do.
// - In the stoppable option the stop bit halts the watchdog for good.
// - Writing anything but the service code to the key register resets.
// - Any single-bit access to the key register resets.
// - The key register always reads a fixed code unlike the service code.
// - In the unstoppable option the counter runs in every state.
// - In the unstoppable option an overflow in stop standby resets.
// - In the stoppable option the counter pauses in halt and stop standby.
// - After standby the counter resumes from its held count and selection.
`timescale 1ns/1ps
`include "wdg_map.svh"

module wdg_top
  import wdg_pkg::*;
(
  input  wire logic      SYS_CLK,
  input  wire logic      RSTN,
  input  wire logic      OPT_UNSTOPPABLE,
  input  wire logic      OSC_RUN,
  input  wire logic      CPU_HALT,
  input  wire logic      CPU_STOP,
  input  wire logic      MODE_WR,
  input  wire logic      MODE_RD,
  input  wire logic      KEY_WR,
  input  wire logic      KEY_RD,
  input  wire logic      BIT_OP,
  input  wire wdg_byte_t WDATA,
  output wdg_byte_t      RDATA,
  output logic           BUS_WAIT,
  output logic           INT_RESET,
  output logic [1:0]     RESET_CAUSE,
  output logic           WDT_ACTIVE
);

  // pin synchronisers, three stages each
  logic       osc_s1;
  logic       osc_s2;
  logic       osc_s3;
  logic       osc_ok;
  logic       opt_s1;
  logic       opt_s2;
  logic       opt_s3;

  // option capture
  logic [1:0] opt_wait;
  logic       opt_done;
  logic       unstoppable;

  // source clock divider
  wdg_byte_t  div_cnt;
  logic       tick;

  // register state
  wdg_byte_t  mode;
  logic       mode_written;
  logic       mode_pend;
  wdg_byte_t  mode_data;
  logic       stopped;
  logic       fault_pend;
  wdg_state_e state;

  // counter
  wdg_cnt_t   count;
  logic       ovf;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
      opt_s1 <= 1'b0;
      opt_s2 <= 1'b0;
      opt_s3 <= 1'b0;
    end
    else
    begin
      osc_s1 <= OSC_RUN;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
      opt_s1 <= OPT_UNSTOPPABLE;
      opt_s2 <= opt_s1;
      opt_s3 <= opt_s2;
    end
  end

  // a level change only counts once the last two stages agree
  wire logic next_osc_ok = (osc_s2 == osc_s3) ? osc_s3 : osc_ok;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      osc_ok <= 1'b0;
    else
      osc_ok <= next_osc_ok;
  end

  // option byte is caught after release, once the synchroniser has settled
  wire logic opt_ready   = !opt_done && (opt_wait == `WDG_OPT_SETTLE) &&
                           (opt_s2 == opt_s3);
  wire logic [1:0] next_opt_wait = (opt_wait == `WDG_OPT_SETTLE) ?
                                   opt_wait : opt_wait + 2'h1;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      opt_wait    <= 2'h0;
      opt_done    <= 1'b0;
      unstoppable <= 1'b0;
    end
    else
    begin
      opt_wait <= next_opt_wait;
      if (opt_ready)
      begin
        opt_done    <= 1'b1;
        unstoppable <= opt_s3;
      end
    end
  end

  // bus decode
  wire logic key_good   = KEY_WR && !BIT_OP && (WDATA == `WDG_KEY_SERVICE);
  wire logic key_bad    = KEY_WR && (BIT_OP || WDATA != `WDG_KEY_SERVICE);
  // bit accesses to the mode register are dropped outright
  wire logic mode_byte  = MODE_WR && !BIT_OP;
  wire logic mode_first = mode_byte && !mode_written && !mode_pend;
  wire logic mode_again = mode_byte && (mode_written || mode_pend);
  wire logic access_bad = key_bad || mode_again;

  // the stored value: fixed upper bits when the option forbids stopping
  wire wdg_byte_t mode_fixed = {`WDG_MODE_TOP_VAL,
                                mode_data[`WDG_MODE_STOP_BIT:0]};
  wire wdg_byte_t next_mode  = unstoppable ? mode_fixed : mode_data;
  wire logic      commit     = mode_pend;
  wire logic      stop_req   = commit && !unstoppable &&
                               mode_data[`WDG_MODE_STOP_BIT];

  // one wait cycle on every mode write, the byte lands when it ends
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      BUS_WAIT <= 1'b0;
    else
      BUS_WAIT <= MODE_WR;
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode_pend <= 1'b0;
      mode_data <= `WDG_MODE_RST;
    end
    else
    begin
      mode_pend <= mode_first;
      if (mode_first)
        mode_data <= WDATA;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      mode         <= `WDG_MODE_RST;
      mode_written <= 1'b0;
    end
    else if (commit)
    begin
      mode         <= next_mode;
      mode_written <= 1'b1;
    end
  end

  // clearing the stop bit later never revives the counter
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      stopped <= 1'b0;
    else if (stop_req)
      stopped <= 1'b1;
  end

  // divider runs only while the source oscillator is seen running
  wire logic      div_last    = div_cnt == `WDG_DIV_LAST;
  wire logic      next_tick   = osc_ok && div_last && !key_good;
  wire wdg_byte_t next_div    = (key_good || div_last) ? 8'h00 :
                                osc_ok ? div_cnt + 8'h01 : div_cnt;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      div_cnt <= 8'h00;
      tick    <= 1'b0;
    end
    else
    begin
      div_cnt <= next_div;
      tick    <= next_tick;
    end
  end

  // run state
  wire logic standby = CPU_HALT || CPU_STOP;
  wire logic firing  = ovf || (fault_pend && osc_ok);
  wdg_state_e next_state;

  always_comb
  begin
    next_state = state;
    case (state)
      WS_INIT:
        if (opt_ready)
          next_state = WS_RUN;
      WS_RUN:
        if (firing)
          next_state = WS_FIRE;
        else if (stop_req)
          next_state = WS_OFF;
        else if (!unstoppable && standby)
          next_state = WS_HOLD;
      WS_HOLD:
        if (firing)
          next_state = WS_FIRE;
        else if (stop_req)
          next_state = WS_OFF;
        else if (!standby)
          next_state = WS_RUN;
      WS_OFF:
        if (firing)
          next_state = WS_FIRE;
      WS_FIRE:
        next_state = WS_FIRE;
      default:
        next_state = WS_INIT;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      state <= WS_INIT;
    else
      state <= next_state;
  end

  // unstoppable: once out of WS_INIT only the oscillator gates the count, standby included
  wire logic cnt_run = unstoppable ? (state != WS_INIT) :
                       (state == WS_RUN) && !standby;

  // the count and selection are held, not cleared, across standby
  wdg_ctr u_ctr
  (
    .clk   (SYS_CLK),
    .rstn  (RSTN),
    .tick  (tick),
    .run   (cnt_run),
    .clr   (key_good),
    .sel   (mode[`WDG_MODE_SEL_HI:`WDG_MODE_SEL_LO]),
    .count (count),
    .ovf   (ovf)
  );

  // a bad access with the source clock stopped waits for it to run again
  wire logic next_fault_pend = fault_pend || access_bad;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
      fault_pend <= 1'b0;
    else
      fault_pend <= next_fault_pend;
  end

  // the reset level is sticky; the system reset that follows clears it
  wire logic       fire_access = fault_pend && osc_ok;
  wire logic       fire_now    = (ovf || fire_access) && !INT_RESET;
  wire logic [1:0] next_cause  = ovf ? `WDG_CAUSE_OVF : `WDG_CAUSE_ACCESS;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      INT_RESET   <= 1'b0;
      RESET_CAUSE <= `WDG_CAUSE_NONE;
    end
    else if (fire_now)
    begin
      INT_RESET   <= 1'b1;
      RESET_CAUSE <= next_cause;
    end
  end

  // read port
  wire wdg_byte_t next_rdata = KEY_RD ? `WDG_KEY_READBACK :
                               MODE_RD ? mode : RDATA;

  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      RDATA      <= 8'h00;
      WDT_ACTIVE <= 1'b0;
    end
    else
    begin
      RDATA      <= next_rdata;
      WDT_ACTIVE <= cnt_run && !stopped;
    end
  end

endmodule // wdg_top

// ### hw/wdg_map.svh
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// mode register layout
`define WDG_MODE_RST      8'h67
`define WDG_MODE_TOP_HI   7
`define WDG_MODE_TOP_LO   5
`define WDG_MODE_TOP_VAL  3'h3
`define WDG_MODE_STOP_BIT 4
`define WDG_MODE_SEL_HI   2
`define WDG_MODE_SEL_LO   0

// service register codes
`define WDG_KEY_SERVICE   8'hac
`define WDG_KEY_READBACK  8'h9a

// counter shape and timing
`define WDG_CNT_W         18
`define WDG_TAP_BASE      5'h0a
`define WDG_DIV_LAST      8'h13
`define WDG_OPT_SETTLE    2'h3

// reset cause encoding
`define WDG_CAUSE_NONE    2'h0
`define WDG_CAUSE_OVF     2'h1
`define WDG_CAUSE_ACCESS  2'h2

`endif

// ### hw/wdg_pkg.sv
`include "wdg_map.svh"

package wdg_pkg;

  typedef logic [`WDG_CNT_W-1:0] wdg_cnt_t;
  typedef logic [7:0]            wdg_byte_t;
  typedef logic [2:0]            wdg_sel_t;

  typedef enum logic [2:0] {
    WS_INIT,
    WS_RUN,
    WS_HOLD,
    WS_OFF,
    WS_FIRE
  } wdg_state_e;

endpackage

// ### hw/wdg_ctr.sv
`timescale 1ns/1ps
`include "wdg_map.svh"

module wdg_ctr
  import wdg_pkg::*;
(
  input  wire logic     clk,
  input  wire logic     rstn,
  input  wire logic     tick,
  input  wire logic     run,
  input  wire logic     clr,
  input  wire wdg_sel_t sel,
  output wdg_cnt_t      count,
  output logic          ovf
);

  wire logic [4:0] tap      = `WDG_TAP_BASE + {2'h0, sel};
  wire wdg_cnt_t   mask     = ~({`WDG_CNT_W{1'b1}} << tap);
  wire logic       at_limit = (count & mask) == mask;
  wire logic       step     = tick && run;
  // clear beats overflow so a service on the last tick still saves the system
  wire wdg_cnt_t   next_count = clr ? '0 :
                                step ? (at_limit ? '0 : count + 18'h1) :
                                count;
  wire logic       next_ovf = !clr && step && at_limit;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      count <= '0;
      ovf   <= 1'b0;
    end
    else
    begin
      count <= next_count;
      ovf   <= next_ovf;
    end
  end

endmodule // wdg_ctr

// ### tb/wdg_top_props.sv
`timescale 1ns/1ps
`include "wdg_map.svh"
module wdg_top_props
  import wdg_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RSTN,
  input wire logic       OPT_UNSTOPPABLE,
  input wire logic       OSC_RUN,
  input wire logic       CPU_HALT,
  input wire logic       CPU_STOP,
  input wire logic       MODE_WR,
  input wire logic       MODE_RD,
  input wire logic       KEY_WR,
  input wire logic       KEY_RD,
  input wire logic       BIT_OP,
  input wire wdg_byte_t  WDATA,
  input wire wdg_byte_t  RDATA,
  input wire logic       BUS_WAIT,
  input wire logic       INT_RESET,
  input wire logic [1:0] RESET_CAUSE,
  input wire logic       WDT_ACTIVE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);
  // oscillator long enough up that the synchroniser sees it
  sequence s_osc; OSC_RUN [*6]; endsequence
  sequence s_fired;
    ##2 (INT_RESET && RESET_CAUSE == `WDG_CAUSE_ACCESS);
  endsequence
  property p_wait; MODE_WR |=> BUS_WAIT; endproperty
  property p_key;
    s_osc ##0 (KEY_WR && !BIT_OP && !INT_RESET &&
      WDATA != `WDG_KEY_SERVICE) |-> s_fired;
  endproperty
  property p_bit;
    s_osc ##0 (KEY_WR && BIT_OP && !INT_RESET) |-> s_fired;
  endproperty
  property p_rd; KEY_RD |=> RDATA == `WDG_KEY_READBACK; endproperty
  property p_defer; !OSC_RUN [*8] |-> !$rose(INT_RESET); endproperty
  property p_sticky;
    INT_RESET |=> INT_RESET && $stable(RESET_CAUSE);
  endproperty
  property p_halt;
    (!OPT_UNSTOPPABLE && (CPU_HALT || CPU_STOP)) [*2] |-> !WDT_ACTIVE;
  endproperty
  property p_run;
    s_osc ##0 (OPT_UNSTOPPABLE && WDT_ACTIVE && !INT_RESET) |=> WDT_ACTIVE;
  endproperty
  a_wait: assert property (p_wait)
    else $error("no wait after mode write");
  a_key: assert property (p_key)
    else $error("bad key without reset");
  a_bit: assert property (p_bit)
    else $error("bit access on key without reset");
  a_rd: assert property (p_rd)
    else $error("key readback wrong");
  a_defer: assert property (p_defer)
    else $error("reset while source clock stopped");
  a_sticky: assert property (p_sticky)
    else $error("internal reset dropped");
  a_halt: assert property (p_halt)
    else $error("counter runs in standby");
  a_run: assert property (p_run)
    else $error("unstoppable counter halted");
endmodule // wdg_top_props

bind wdg_top wdg_top_props i_props (.SYS_CLK, .RSTN, .OPT_UNSTOPPABLE,
  .OSC_RUN, .CPU_HALT, .CPU_STOP, .MODE_WR, .MODE_RD, .KEY_WR, .KEY_RD,
  .BIT_OP, .WDATA, .RDATA, .BUS_WAIT, .INT_RESET, .RESET_CAUSE, .WDT_ACTIVE);

// ### tb/wdg_top_tb.sv
`timescale 1ns/1ps
module wdg_top_tb
  import wdg_pkg::*;
;
  logic       clk = 0, rstn = 0, opt = 0, osc = 1, halt = 0, stp = 0;
  logic       mwr = 0, mrd = 0, kwr = 0, krd = 0, bop = 0;
  wdg_byte_t  wd = 8'h00, rdt, v;
  logic       bw, irst, act;
  logic [1:0] cause;
  int         failures = 0, n_checks = 0, cyc = 0;
  wdg_top i_dut (.SYS_CLK(clk), .RSTN(rstn), .OPT_UNSTOPPABLE(opt),
    .OSC_RUN(osc), .CPU_HALT(halt), .CPU_STOP(stp), .MODE_WR(mwr),
    .MODE_RD(mrd), .KEY_WR(kwr), .KEY_RD(krd), .BIT_OP(bop), .WDATA(wd),
    .RDATA(rdt), .BUS_WAIT(bw), .INT_RESET(irst), .RESET_CAUSE(cause),
    .WDT_ACTIVE(act));
  initial forever #25 clk = ~clk;
  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // run is about 90k cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 100000)
    begin
      failures++;
      end_of_test();
    end
  end
  task chk(input logic [7:0] s, input logic [7:0] e);
    n_checks++;
    if (s !== e)
    begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // every task starts and ends 1 ns after a rising edge
  task tk(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task rst(input logic o);
    rstn = 0;
    opt = o;
    osc = 1;
    halt = 0;
    stp = 0;
    tk(6);
    rstn = 1;
    tk(8);
  endtask
  task wr(input logic m, input logic b, input wdg_byte_t d);
    mwr = m;
    kwr = !m;
    bop = b;
    wd = d;
    tk(1);
    mwr = 0;
    kwr = 0;
    bop = 0;
    if (m)
      chk(bw, 1);
    tk(1);
  endtask
  task rd(input logic m, output wdg_byte_t r);
    mrd = m;
    krd = !m;
    tk(1);
    mrd = 0;
    krd = 0;
    r = rdt;
    // one idle edge so a following read raises its strobe afresh
    tk(1);
  endtask
  task wt(input int n);
    repeat (n)
      if (irst !== 1'b1)
        tk(1);
  endtask
  initial
  begin
    rst(0);
    rd(0, v);
    chk(v, 8'h9a);
    wr(1, 1, 8'h00);
    rd(1, v);
    chk(v, 8'h67);
    // the bench has no subsystem clock: mode writes only with osc running
    wr(1, 0, 8'h60);
    rd(1, v);
    chk(v, 8'h60);
    tk(15000);
    // service well before overflow, as the auxiliary timer would
    wr(0, 0, 8'hac);
    tk(10000);
    halt = 1;
    tk(30000);
    chk(irst, 0);
    halt = 0;
    tk(10000);
    chk(irst, 0);
    wt(1000);
    chk({5'h00, irst, cause}, 8'h05);
    rst(0);
    wr(1, 0, 8'h70);
    tk(4);
    chk(act, 0);
    wr(1, 0, 8'h60);
    tk(2);
    chk({5'h00, irst, cause}, 8'h06);
    rst(0);
    osc = 0;
    tk(8);
    wr(0, 0, 8'h55);
    tk(20);
    chk(irst, 0);
    osc = 1;
    tk(8);
    chk({5'h00, irst, cause}, 8'h06);
    rst(0);
    wr(0, 1, 8'hac);
    tk(2);
    chk({5'h00, irst, cause}, 8'h06);
    // wrong key with the oscillator running fires at once
    rst(0);
    wr(0, 0, 8'h3c);
    tk(2);
    chk({5'h00, irst, cause}, 8'h06);
    rst(1);
    wr(1, 0, 8'h10);
    rd(1, v);
    chk(v & 8'he0, 8'h60);
    stp = 1;
    tk(4);
    chk(act, 1);
    wt(22000);
    chk({5'h00, irst, cause}, 8'h05);
    end_of_test();
  end
endmodule // wdg_top_tb
